//--- frt_dual_clock_fifo.sv
`timescale 1ns/1ps
`default_nettype none
module frt_dual_clock_fifo
  import frt_pkg::*;
(
  input  wire logic                   clk,
  input  wire logic                   rst_n,
  input  wire logic                   wrValid,
  input  wire logic [WIDE_BITS-1:0]   wrData,
  output logic                        wrFull,
  input  wire logic                   rdReq,
  output logic      [NARROW_BITS-1:0] rdData,
  output logic                        rdValid
);
  logic [WIDE_BITS-1:0]   mem [FIFO_DEPTH];
  logic [FIFO_AW:0]       wp_reg;
  logic [FIFO_AW:0]       wp_next;
  logic [FIFO_AW:0]       rp_reg;
  logic [FIFO_AW:0]       rp_next;
  logic [1:0]             sub_reg;
  logic [1:0]             sub_next;
  logic [NARROW_BITS-1:0] rdData_reg;
  logic [NARROW_BITS-1:0] rdData_next;
  logic                   rdValid_reg;
  logic                   rdValid_next;
  logic                   empty;
  logic                   rdFire;

  assign empty  = (wp_reg == rp_reg);
  assign wrFull = (wp_reg[FIFO_AW-1:0] == rp_reg[FIFO_AW-1:0]) && (wp_reg[FIFO_AW] != rp_reg[FIFO_AW]);
  assign rdFire = rdReq && !empty;

  // wide words go in, each leaves as SLICES narrow words, lowest slice first
  always_comb begin
    wp_next      = wp_reg;
    rp_next      = rp_reg;
    sub_next     = sub_reg;
    rdData_next  = rdData_reg;
    rdValid_next = rdFire;
    if (wrValid && !wrFull) wp_next = wp_reg + 1'b1;
    if (rdFire) begin // RL11 RL12
      rdData_next = mem[rp_reg[FIFO_AW-1:0]][sub_reg*NARROW_BITS +: NARROW_BITS];
      sub_next    = sub_reg + 1'b1;
      if (sub_reg == 2'(SLICES - 1)) rp_next = rp_reg + 1'b1;
    end
  end

  always_ff @(posedge clk) begin
    if (wrValid && !wrFull) mem[wp_reg[FIFO_AW-1:0]] <= wrData;
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      wp_reg      <= '0;
      rp_reg      <= '0;
      sub_reg     <= '0;
      rdData_reg  <= '0;
      rdValid_reg <= 1'b0;
    end else begin
      wp_reg      <= wp_next;
      rp_reg      <= rp_next;
      sub_reg     <= sub_next;
      rdData_reg  <= rdData_next;
      rdValid_reg <= rdValid_next;
    end
  end

  assign rdData  = rdData_reg;
  assign rdValid = rdValid_reg;
endmodule : frt_dual_clock_fifo
`default_nettype wire

//--- frt_lane_sink.sv
`timescale 1ns/1ps
`default_nettype none
module frt_lane_sink
  import frt_pkg::*;
(
  input  wire logic                   clk,
  input  wire logic                   rst_n,
  input  wire logic [NARROW_BITS-1:0] txData,
  input  wire logic                   txValid,
  input  wire logic                   fourLaneRate,
  input  wire logic [1:0]             oversampleSelect,
  output logic      [NARROW_BITS-1:0] laneChars,
  output logic      [2:0]             charCount
);
  logic [NARROW_BITS-1:0] chars_reg;
  logic [NARROW_BITS-1:0] chars_next;
  logic [2:0]             count_reg;
  logic [2:0]             count_next;
  // lanes take a word every cycle and never stall the source
  always_comb begin
    chars_next = txData;
    count_next = 3'h0;
    if (txValid && oversampleSelect != 2'h2) count_next = fourLaneRate ? 3'h4 : 3'h3;
  end
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      chars_reg <= '0;
      count_reg <= 3'h0;
    end else begin
      chars_reg <= chars_next;
      count_reg <= count_next;
    end
  end
  assign laneChars = chars_reg;
  assign charCount = count_reg;
endmodule : frt_lane_sink
`default_nettype wire

//--- frt_pkg.sv
`default_nettype none
package frt_pkg;
  localparam int CHAR_BITS     = 16;
  localparam int ENC_BITS      = 18;
  localparam int CHARS_PER_CLK = 16;
  localparam int LANES         = 4;
  localparam int WIDE_BITS     = CHARS_PER_CLK * ENC_BITS;
  localparam int NARROW_BITS   = LANES * ENC_BITS;
  localparam int SLICES        = WIDE_BITS / NARROW_BITS;
  localparam int FIFO_AW       = 2;
  localparam int FIFO_DEPTH    = 4;
  localparam int RS_BLOCKS     = 4;
  localparam int RS_PAR        = 4;
  localparam logic [7:0] RS_N  = 8'hff;
  localparam logic [7:0] RS_K  = 8'hfb;
  localparam logic [9:0] MAX_PKT_DATA = 10'h3fe;
  localparam logic [8:0] CB_PAYLOAD   = 9'h1f6;
  localparam logic [8:0] CB_PARITY    = 9'h008;
  localparam logic [1:0] CB_PER_SB    = 2'h3;
  localparam logic [8:0] COMMA_CNT    = 9'h004;
  localparam logic [7:0] GF_POLY = 8'h1d;
  localparam logic [7:0] GEN3    = 8'h0f;
  localparam logic [7:0] GEN2    = 8'h36;
  localparam logic [7:0] GEN1    = 8'h78;
  localparam logic [7:0] GEN0    = 8'h40;
  localparam logic [15:0] SSB_CODE = 16'h0f5a;
  localparam logic [15:0] SR_CODE  = 16'hf0a5;
  localparam logic [15:0] MAP_DATA = 16'h0001;
  localparam logic [15:0] MAP_GAP  = 16'h0000;
  localparam logic [1:0]  ENC_DATA = 2'h1;
  localparam logic [1:0]  ENC_CTRL = 2'h2;
  localparam logic [15:0] SCR_SEED = 16'hffff;
  localparam logic [15:0] SCR_TAPS = 16'h0039;
  localparam logic [2:0]  OS_MIN   = 3'h3;
  localparam logic [2:0]  OS_MID   = 3'h4;
  localparam logic [2:0]  OS_MAX   = 3'h5;
  typedef enum logic [1:0] {OS_FRL, OS_LEGACY_HI, OS_LEGACY_LO} frt_os_e;
  typedef enum logic [1:0] {SEQ_COMMA, SEQ_DATA, SEQ_PARITY} frt_seq_e;
  typedef struct packed {
    logic        valid;
    logic        last;
    logic [15:0] data;
  } frt_in_s;
  typedef struct packed {
    logic        ctrl;
    logic [15:0] data;
  } frt_char_s;
endpackage : frt_pkg
`default_nettype wire

//--- frt_rs_parity.sv
`timescale 1ns/1ps
`default_nettype none
module frt_rs_parity
  import frt_pkg::*;
(
  input  wire logic         clk,
  input  wire logic         rst_n,
  input  wire logic         clear,
  input  wire logic         symValid,
  input  wire logic [15:0]  syms,
  input  wire logic         sel,
  output logic      [127:0] parityWords
);
  function automatic logic [7:0] gfMul(input logic [7:0] a, input logic [7:0] b);
    logic [7:0] acc;
    logic [7:0] x;
    acc = 8'h00;
    x   = a;
    for (int i = 0; i < 8; i++) begin
      if (b[i]) acc = acc ^ x;
      x = {x[6:0], 1'b0} ^ (x[7] ? GF_POLY : 8'h00); // RL7
    end
    return acc;
  endfunction : gfMul

  logic [RS_BLOCKS-1:0][RS_PAR-1:0][7:0] parAll;

  genvar b;
  generate
    for (b = 0; b < RS_BLOCKS; b++) begin : g_blk
      logic [RS_PAR-1:0][7:0] par_reg;
      logic [RS_PAR-1:0][7:0] par_next;
      logic [7:0]             sym;
      logic [7:0]             fb;
      // systematic division by the generator, data itself is passed on untouched
      always_comb begin
        par_next = par_reg;
        sym      = (b % 2 == 0) ? syms[7:0] : syms[15:8];
        fb       = sym ^ par_reg[3];
        if (clear) begin
          par_next = '0;
        end else if (symValid && sel == 1'(b / 2)) begin // RL6 RL19
          par_next[3] = par_reg[2] ^ gfMul(fb, GEN3); // RL8 RL5
          par_next[2] = par_reg[1] ^ gfMul(fb, GEN2); // RL8
          par_next[1] = par_reg[0] ^ gfMul(fb, GEN1); // RL8
          par_next[0] = gfMul(fb, GEN0); // RL8
        end
      end
      always_ff @(posedge clk) begin
        if (!rst_n) par_reg <= '0;
        else        par_reg <= par_next;
      end
      assign parAll[b] = par_reg;
    end
    // parity word i pairs blocks 2*(i%2) and 2*(i%2)+1, highest symbol first
    for (b = 0; b < 8; b++) begin : g_word
      assign parityWords[b*16 +: 16] = {parAll[2*(b%2)+1][3-b/2], parAll[2*(b%2)][3-b/2]}; // RL6
    end
  endgenerate
endmodule : frt_rs_parity
`default_nettype wire

//--- frt_tx_path.sv
// Notes on behaviour
// RL1 - a packet is one map character then 0 to 1022 data characters
// RL2 - a super block is four character blocks, each carrying one or more packets
// RL3 - a character block holds 502 packet characters plus 8 parity characters
// RL4 - each super block is preceded by four start or scrambler-reset comma characters
// RL5 - parity uses a 255/251 Reed-Solomon code over the 256-element field
// RL6 - data is split across four parity blocks, parity interleaved onto the lanes
// RL7 - field arithmetic uses x^8+x^4+x^3+x^2+1
// RL8 - generator is x^4+15x^3+54x^2+120x+64
// RL9 - all data is scrambled, comma characters are not
// RL10 - scrambled data is coded into 18-bit characters
// RL11 - characters cross to the lane side through a mixed-width fifo
// RL12 - sixteen 18-bit characters per write, lanes times 18 bits per read
// RL13 - the surrounding clocks keep equal throughput on both fifo sides
// RL14 - the oversampler repeats every input bit by the factor 3, 4 or 5
// RL15 - oversampling only in the slow mode; one fifo read per factor cycles
// RL16 - a one-cycle enable every factor cycles is the fifo read request
// RL17 - select 0 is fixed-rate mode, 1 legacy fast, 2 legacy slow
// RL18 - four lanes; three-lane rates leave the fourth lane empty
// RL19 - parity is systematic, four symbols per codeword, short blocks allowed
`timescale 1ns/1ps
`default_nettype none
module frt_tx_path
  import frt_pkg::*;
(
  input  wire frt_in_s                inWord,
  output logic                        inReady,
  input  wire logic                   clk,
  input  wire logic                   rst_n,
  input  wire logic [1:0]             oversampleSelect,
  input  wire logic [2:0]             osFactor,
  input  wire logic                   fourLaneRate,
  input  wire logic                   scrResetReq,
  output logic      [NARROW_BITS-1:0] txData,
  output logic                        txValid,
  output logic                        sbStart
);
  // packet and block sequencer state
  frt_seq_e             seq_reg;
  frt_seq_e             seq_next;
  logic [8:0]           cnt_reg;
  logic [8:0]           cnt_next;
  logic [1:0]           cb_reg;
  logic [1:0]           cb_next;
  logic                 inPkt_reg;
  logic                 inPkt_next;
  logic [9:0]           pktLen_reg;
  logic [9:0]           pktLen_next;
  logic                 srPend_reg;
  logic                 srPend_next;
  logic                 grpSr_reg;
  logic                 grpSr_next;
  logic [15:0]          scr_reg;
  logic [15:0]          scr_next;
  logic                 inReady_reg;
  logic                 inReady_next;
  logic                 sbStart_reg;
  logic                 sbStart_next;
  // character accumulator
  logic [WIDE_BITS-1:0] acc_reg;
  logic [WIDE_BITS-1:0] acc_next;
  logic [3:0]           accPos_reg;
  logic [3:0]           accPos_next;
  logic                 accFull_reg;
  logic                 accFull_next;
  // oversampler and enable generator
  logic [2:0]           ce_reg;
  logic [2:0]           ce_next;
  logic                 cePulse_reg;
  logic                 cePulse_next;
  logic [NARROW_BITS-1:0] osWord_reg;
  logic [NARROW_BITS-1:0] osWord_next;
  logic [2:0]           phase_reg;
  logic [2:0]           phase_next;
  logic [NARROW_BITS-1:0] txData_reg;
  logic [NARROW_BITS-1:0] txData_next;
  logic                 txValid_reg;
  logic                 txValid_next;
  // combinational
  frt_char_s            ch;
  logic                 emit;
  logic                 rsValid;
  logic                 rsClear;
  logic                 push;
  logic [15:0]          scrChar;
  logic [4:0]           posInc;
  logic [127:0]         rsParity;
  logic                 fifoFull;
  logic                 rdReq;
  logic [NARROW_BITS-1:0] rdData;
  logic                 rdValid;
  logic [2:0]           fEff;
  logic                 slow;
  logic [NARROW_BITS-1:0] osSrc;
  logic [2:0]           osPh;
  logic [NARROW_BITS-1:0] osBits;

  function automatic logic [15:0] scrStep(input logic [15:0] s);
    logic [15:0] x;
    x = s;
    for (int i = 0; i < CHAR_BITS; i++) begin
      x = x[0] ? ((x >> 1) ^ SCR_TAPS) : (x >> 1);
    end
    return x;
  endfunction : scrStep

  function automatic logic [4:0] osIndex(input logic [2:0] ph, input logic [4:0] j, input logic [2:0] f);
    logic [7:0] t;
    t = {5'h00, ph} * 8'h12 + {3'h0, j};
    t = t / {5'h00, f};
    // idle phases past the factor would otherwise index beyond the lane
    return (t >= 8'(ENC_BITS)) ? 5'(ENC_BITS - 1) : t[4:0];
  endfunction : osIndex

  // ---------------- sequencer, scrambler, encoder, accumulator
  always_comb begin
    seq_next     = seq_reg;
    cnt_next     = cnt_reg;
    cb_next      = cb_reg;
    inPkt_next   = inPkt_reg;
    pktLen_next  = pktLen_reg;
    srPend_next  = srPend_reg | scrResetReq;
    grpSr_next   = grpSr_reg;
    scr_next     = scr_reg;
    acc_next     = acc_reg;
    accPos_next  = accPos_reg;
    accFull_next = accFull_reg;
    sbStart_next = 1'b0;
    ch           = '0;
    emit         = 1'b0;
    rsValid      = 1'b0;
    rsClear      = 1'b0;
    scrChar      = 16'h0000;
    posInc       = 5'h00;
    push         = accFull_reg && !fifoFull;
    if (push) begin
      accFull_next = 1'b0;
      acc_next     = '0;
    end
    if (!accFull_reg) begin
      case (seq_reg)
        SEQ_COMMA: begin
          emit     = 1'b1;
          ch.ctrl  = 1'b1;
          cnt_next = cnt_reg + 9'h001;
          if (cnt_reg == 9'h000) begin
            // scrambler reset is chosen for the whole group at its first character
            grpSr_next   = srPend_reg;
            srPend_next  = scrResetReq;
            sbStart_next = 1'b1;
            ch.data      = srPend_reg ? SR_CODE : SSB_CODE; // RL4
          end else begin
            ch.data = grpSr_reg ? SR_CODE : SSB_CODE; // RL4
          end
          if (cnt_reg == COMMA_CNT - 9'h001) begin
            seq_next = SEQ_DATA;
            cnt_next = 9'h000;
            rsClear  = 1'b1;
          end
        end
        SEQ_DATA: begin
          if (!inPkt_reg) begin
            // a map character opens a packet; with no data waiting it is an empty packet
            emit        = 1'b1;
            ch.data     = inWord.valid ? MAP_DATA : MAP_GAP; // RL1
            inPkt_next  = inWord.valid;
            pktLen_next = 10'h000;
          end else if (inReady_reg && inWord.valid) begin
            emit        = 1'b1;
            ch.data     = inWord.data;
            pktLen_next = pktLen_reg + 10'h001;
            if (inWord.last || pktLen_reg == MAX_PKT_DATA - 10'h001) inPkt_next = 1'b0; // RL1
          end
          if (emit) begin
            rsValid  = 1'b1;
            cnt_next = cnt_reg + 9'h001;
            if (cnt_reg == CB_PAYLOAD - 9'h001) begin // RL3
              seq_next = SEQ_PARITY;
              cnt_next = 9'h000;
            end
          end
        end
        SEQ_PARITY: begin
          emit     = 1'b1;
          ch.data  = rsParity[cnt_reg[2:0]*16 +: 16]; // RL6
          cnt_next = cnt_reg + 9'h001;
          if (cnt_reg == CB_PARITY - 9'h001) begin // RL3
            cnt_next = 9'h000;
            cb_next  = cb_reg + 2'h1;
            rsClear  = 1'b1;
            seq_next = (cb_reg == CB_PER_SB) ? SEQ_COMMA : SEQ_DATA; // RL2
          end
        end
        default: begin
          seq_next = SEQ_COMMA;
          cnt_next = 9'h000;
        end
      endcase
    end
    if (emit) begin
      if (ch.ctrl) begin
        scrChar = ch.data; // RL9
        if (ch.data == SR_CODE) scr_next = SCR_SEED;
      end else begin
        scrChar  = ch.data ^ scr_reg; // RL9
        scr_next = scrStep(scr_reg);
      end
      acc_next[accPos_reg*ENC_BITS +: ENC_BITS] = {ch.ctrl ? ENC_CTRL : ENC_DATA, scrChar}; // RL10
      posInc = {1'b0, accPos_reg} + 5'h01;
      if (!fourLaneRate && posInc[1:0] == 2'h3) posInc = posInc + 5'h01; // RL18
      accPos_next = posInc[3:0];
      if (posInc[4]) accFull_next = 1'b1; // RL12
    end
    inReady_next = (seq_next == SEQ_DATA) && inPkt_next && !accFull_next;
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      seq_reg     <= SEQ_COMMA;
      cnt_reg     <= 9'h000;
      cb_reg      <= 2'h0;
      inPkt_reg   <= 1'b0;
      pktLen_reg  <= 10'h000;
      srPend_reg  <= 1'b1;
      grpSr_reg   <= 1'b0;
      scr_reg     <= SCR_SEED;
      acc_reg     <= '0;
      accPos_reg  <= 4'h0;
      accFull_reg <= 1'b0;
      inReady_reg <= 1'b0;
      sbStart_reg <= 1'b0;
    end else begin
      seq_reg     <= seq_next;
      cnt_reg     <= cnt_next;
      cb_reg      <= cb_next;
      inPkt_reg   <= inPkt_next;
      pktLen_reg  <= pktLen_next;
      srPend_reg  <= srPend_next;
      grpSr_reg   <= grpSr_next;
      scr_reg     <= scr_next;
      acc_reg     <= acc_next;
      accPos_reg  <= accPos_next;
      accFull_reg <= accFull_next;
      inReady_reg <= inReady_next;
      sbStart_reg <= sbStart_next;
    end
  end

  // parity over the unscrambled stream; even characters feed blocks 0/1, odd ones 2/3
  frt_rs_parity u_rs (
    .clk         (clk),
    .rst_n       (rst_n),
    .clear       (rsClear),
    .symValid    (rsValid),
    .syms        (ch.data),
    .sel         (cnt_reg[0]),
    .parityWords (rsParity)
  );

  frt_dual_clock_fifo u_fifo (
    .clk     (clk),
    .rst_n   (rst_n),
    .wrValid (push),
    .wrData  (acc_reg),
    .wrFull  (fifoFull),
    .rdReq   (rdReq),
    .rdData  (rdData),
    .rdValid (rdValid)
  );

  // ---------------- clock enable generator and oversampler
  assign fEff  = (osFactor == OS_MID || osFactor == OS_MAX) ? osFactor : OS_MIN; // RL14
  assign slow  = (oversampleSelect == OS_LEGACY_LO); // RL17
  assign rdReq = slow ? cePulse_reg : 1'b1; // RL15 RL16
  assign osSrc = rdValid ? rdData : osWord_reg;
  assign osPh  = rdValid ? 3'h0 : ((phase_reg < fEff) ? phase_reg + 3'h1 : phase_reg);

  genvar g;
  generate
    for (g = 0; g < NARROW_BITS; g++) begin : g_os
      localparam int         LANE = g / ENC_BITS;
      localparam logic [4:0] JIDX = 5'(g % ENC_BITS);
      // output bit j of phase p carries input bit (p*18+j)/factor of its own lane
      assign osBits[g] = osSrc[LANE*ENC_BITS + int'(osIndex(osPh, JIDX, fEff))]; // RL14
    end
  endgenerate

  always_comb begin
    ce_next      = (ce_reg >= fEff - 3'h1) ? 3'h0 : ce_reg + 3'h1;
    cePulse_next = slow && (ce_reg >= fEff - 3'h1); // RL16
    osWord_next  = osWord_reg;
    phase_next   = phase_reg;
    if (slow) begin
      osWord_next  = osSrc;
      phase_next   = osPh;
      txData_next  = osBits;
      txValid_next = osPh < fEff; // RL15
    end else begin
      txData_next  = rdData;
      txValid_next = rdValid;
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      ce_reg      <= 3'h0;
      cePulse_reg <= 1'b0;
      osWord_reg  <= '0;
      phase_reg   <= OS_MAX;
      txData_reg  <= '0;
      txValid_reg <= 1'b0;
    end else begin
      ce_reg      <= ce_next;
      cePulse_reg <= cePulse_next;
      osWord_reg  <= osWord_next;
      phase_reg   <= phase_next;
      txData_reg  <= txData_next;
      txValid_reg <= txValid_next;
    end
  end

  assign inReady = inReady_reg;
  assign txData  = txData_reg;
  assign txValid = txValid_reg;
  assign sbStart = sbStart_reg;
endmodule : frt_tx_path
`default_nettype wire

//--- frt_tx_path_properties.sv
`timescale 1ns/1ps
`default_nettype none
module frt_tx_path_properties
  import frt_pkg::*;
(
  input wire frt_in_s                inWord,
  input wire logic                   inReady,
  input wire logic                   clk,
  input wire logic                   rst_n,
  input wire logic [1:0]             oversampleSelect,
  input wire logic [2:0]             osFactor,
  input wire logic                   fourLaneRate,
  input wire logic                   scrResetReq,
  input wire logic [NARROW_BITS-1:0] txData,
  input wire logic                   txValid,
  input wire logic                   sbStart
);
  logic       slow;
  logic       tripOk;
  logic [2:0] facLast;
  logic [2:0] ph_reg;
  logic [2:0] ph_next;
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);
  assign slow    = (oversampleSelect == 2'h2);
  assign facLast = (osFactor == OS_MID || osFactor == OS_MAX) ? osFactor - 3'h1 : OS_MIN - 3'h1;
  always_comb begin
    tripOk = 1'b1;
    for (int i = 0; i < NARROW_BITS / 3; i++) begin
      if (txData[3*i +: 3] != 3'h0 && txData[3*i +: 3] != 3'h7) tripOk = 1'b0;
    end
  end
  // phase of the current slow-mode word
  always_comb begin
    ph_next = 3'h0;
    if (txValid && slow && ph_reg != facLast) ph_next = ph_reg + 3'h1;
  end
  always_ff @(posedge clk) begin
    if (!rst_n) ph_reg <= 3'h0;
    else ph_reg <= ph_next;
  end
  property p_lane3_idle;
    txValid && !fourLaneRate |-> txData[71:54] == '0;
  endproperty
  a_lane3_idle: assert property (p_lane3_idle) else $error("lane 3 busy at a three-lane rate");
  property p_lane3_used;
    txValid && fourLaneRate && !slow |-> ^txData[71:70];
  endproperty
  a_lane3_used: assert property (p_lane3_used) else $error("lane 3 carries no character");
  property p_char_code;
    txValid && !slow |-> ^txData[17:16] && ^txData[35:34] && ^txData[53:52];
  endproperty
  a_char_code: assert property (p_char_code) else $error("character prefix not 18-bit code");
  property p_os_triple;
    txValid && slow && osFactor == OS_MIN |-> tripOk;
  endproperty
  a_os_triple: assert property (p_os_triple) else $error("bits not repeated three times");
  property p_os_hold;
    txValid && slow && ph_reg != facLast |=> txValid;
  endproperty
  a_os_hold: assert property (p_os_hold) else $error("slow word shorter than factor");
  property p_os_end;
    slow && $fell(txValid) |-> $past(ph_reg) == facLast;
  endproperty
  a_os_end: assert property (p_os_end) else $error("slow run not a factor multiple");
  property p_sb_pulse;
    sbStart |=> !sbStart;
  endproperty
  a_sb_pulse: assert property (p_sb_pulse) else $error("super block start longer than a cycle");
  property p_comma_out;
    sbStart && !slow |-> ##[1:60] (txValid && (txData[17:16] == 2'h2 || txData[35:34] == 2'h2
      || txData[53:52] == 2'h2 || txData[71:70] == 2'h2));
  endproperty
  a_comma_out: assert property (p_comma_out) else $error("no comma after super block start");
endmodule : frt_tx_path_properties
`default_nettype wire

//--- test_frl_tx_framing_fec_oversampler.sv
`timescale 1ns/1ps
`default_nettype none
module test_frl_tx_framing_fec_oversampler
  import frt_pkg::*;
;
  localparam int SB_CHARS = 4 + 4 * (502 + 8);
  logic                   clk = 1'b0;
  logic                   rst_n;
  frt_in_s                inWord;
  logic                   inReady;
  logic [1:0]             oversampleSelect;
  logic [2:0]             osFactor;
  logic                   fourLaneRate;
  logic                   scrResetReq;
  logic [NARROW_BITS-1:0] txData;
  logic [NARROW_BITS-1:0] laneChars;
  logic                   txValid;
  logic                   sbStart;
  logic [2:0]             charCount;
  logic [31:0]            seed;
  logic [7:0]             srMask;
  logic                   track;
  logic                   longPkt;
  int                     failures;
  int                     cmpCount;
  int                     cycles;
  int                     charIdx;
  int                     sbIdx;
  int                     sbSeen;
  int                     runLen;
  int                     runs;
  int                     pos;
  logic [15:0]            refScr;
  logic [15:0]            rxChar;
  logic [3:0][3:0][7:0]   refPar;

  always #25 clk = ~clk;

  frt_tx_path u_dut (.inWord(inWord), .inReady(inReady), .clk(clk), .rst_n(rst_n),
    .oversampleSelect(oversampleSelect), .osFactor(osFactor), .fourLaneRate(fourLaneRate),
    .scrResetReq(scrResetReq), .txData(txData), .txValid(txValid), .sbStart(sbStart));
  frt_lane_sink u_sink (.clk(clk), .rst_n(rst_n), .txData(txData), .txValid(txValid),
    .fourLaneRate(fourLaneRate), .oversampleSelect(oversampleSelect), .laneChars(laneChars),
    .charCount(charCount));

  function automatic logic [31:0] xs(input logic [31:0] s);
    logic [31:0] t;
    t = s ^ (s << 13);
    t = t ^ (t >> 17);
    return t ^ (t << 5);
  endfunction : xs

  function automatic logic [17:0] comma_char(input logic sr);
    return {ENC_CTRL, sr ? SR_CODE : SSB_CODE};
  endfunction : comma_char

  function automatic logic [15:0] scr_step(input logic [15:0] s);
    for (int i = 0; i < CHAR_BITS; i++) begin
      s = s[0] ? ((s >> 1) ^ SCR_TAPS) : (s >> 1);
    end
    return s;
  endfunction : scr_step

  function automatic logic [7:0] gf_mul(input logic [7:0] a, input logic [7:0] b);
    logic [7:0] acc;
    acc = 8'h00;
    for (int i = 0; i < 8; i++) begin
      if (b[i]) acc = acc ^ a;
      a = {a[6:0], 1'b0} ^ (a[7] ? GF_POLY : 8'h00);
    end
    return acc;
  endfunction : gf_mul

  // one symbol into a parity register set, highest symbol in the top byte
  function automatic logic [31:0] rs_step(input logic [31:0] p, input logic [7:0] s);
    logic [7:0] fb;
    fb = s ^ p[31:24];
    return {p[23:16] ^ gf_mul(fb, GEN3), p[15:8] ^ gf_mul(fb, GEN2), p[7:0] ^ gf_mul(fb, GEN1), gf_mul(fb, GEN0)};
  endfunction : rs_step

  task automatic check(input string name, input logic [31:0] expv, input logic [31:0] got);
    cmpCount++;
    if (got !== expv) begin
      failures++;
      $display("[ERR] %s expected %h seen %h", name, expv, got);
    end
  endtask : check

  task automatic print_verdict();
    $display("comparisons %0d failures %0d", cmpCount, failures);
    if (failures == 0 && cmpCount > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask : print_verdict

  task automatic restart(input logic [1:0] mode, input logic [2:0] fac, input logic four);
    @(posedge clk);
    track = 1'b0;
    rst_n <= 1'b0;
    oversampleSelect <= mode;
    osFactor <= fac;
    fourLaneRate <= four;
    repeat (4) @(posedge clk);
    @(negedge clk);
    check("reset outputs", 32'h0, 32'({inReady, txValid, sbStart, |txData}));
    @(posedge clk);
    rst_n <= 1'b1;
    charIdx = 0;
    sbIdx = 0;
    sbSeen = 0;
    srMask = 8'h01;
    runLen = 0;
    runs = 0;
    track = (mode != 2'h2);
  endtask : restart

  // new word only once the offered one is taken
  always @(posedge clk) begin
    if (!inWord.valid || inReady) begin
      seed = xs(seed);
      inWord <= '{valid: (oversampleSelect == 2'h2) ? seed[1:0] == 2'h0 : seed[3:0] != 4'h0,
                  last: !longPkt && seed[10:4] == 7'h0, data: seed[31:16]};
    end
  end

  always @(negedge clk) begin
    if (track) begin
      for (int i = 0; i < charCount; i++) begin
        if (charIdx < 4) begin
          check("comma", 32'(comma_char(srMask[sbIdx])), 32'(laneChars[18*i +: 18]));
          if (srMask[sbIdx]) refScr = SCR_SEED;
          refPar = '0;
        end else begin
          check("data prefix", 32'(ENC_DATA), 32'(laneChars[18*i+16 +: 2]));
          rxChar = laneChars[18*i +: 16] ^ refScr;
          refScr = scr_step(refScr);
          pos = (charIdx - 4) % 510;
          if (charIdx == 4 && sbIdx == 0) check("first map", 32'h0, 32'(rxChar >> 1));
          if (pos < 502) begin
            refPar[2*(pos%2)] = rs_step(refPar[2*(pos%2)], rxChar[7:0]);
            refPar[2*(pos%2)+1] = rs_step(refPar[2*(pos%2)+1], rxChar[15:8]);
          end else begin
            pos = pos - 502;
            check("parity", 32'({refPar[2*(pos%2)+1][3-pos/2], refPar[2*(pos%2)][3-pos/2]}), 32'(rxChar));
            if (pos == 7) refPar = '0;
          end
        end
        charIdx++;
        if (charIdx == SB_CHARS) begin
          charIdx = 0;
          sbIdx++;
        end
      end
    end
    if (rst_n && sbStart) sbSeen++;
    if (rst_n && oversampleSelect == 2'h2) begin
      if (txValid) runLen++;
      else if (runLen > 0) begin
        check("slow run", 32'h0, 32'(runLen % osFactor));
        runs++;
        runLen = 0;
      end
    end
  end

  always @(posedge clk) begin
    cycles++;
    if (cycles == 40000) begin
      failures++;
      $display("[ERR] run cycles expected below 40000 seen %0d", cycles);
      print_verdict();
    end
  end

  initial begin
    inWord = '0;
    rst_n = 1'b0;
    oversampleSelect = 2'h0;
    osFactor = OS_MIN;
    fourLaneRate = 1'b1;
    scrResetReq = 1'b0;
    seed = 32'h588da013;
    track = 1'b0;
    longPkt = 1'b1;
    failures = 0;
    cmpCount = 0;
    cycles = 0;
    restart(2'h0, OS_MIN, 1'b1);
    while (sbSeen < 2) @(posedge clk);
    repeat (10) @(posedge clk);
    scrResetReq <= 1'b1;
    srMask[2] = 1'b1;
    @(posedge clk);
    scrResetReq <= 1'b0;
    while (sbIdx < 3) @(posedge clk);
    longPkt = 1'b0;
    restart(2'h1, OS_MIN, 1'b0);
    while (sbIdx < 2) @(posedge clk);
    for (int f = 3; f <= 5; f++) begin
      restart(2'h2, 3'(f), 1'b1);
      while (runs < 12) @(posedge clk);
    end
    print_verdict();
  end
endmodule : test_frl_tx_framing_fec_oversampler

bind frt_tx_path frt_tx_path_properties u_props (.inWord(inWord), .inReady(inReady), .clk(clk),
  .rst_n(rst_n), .oversampleSelect(oversampleSelect), .osFactor(osFactor), .fourLaneRate(fourLaneRate),
  .scrResetReq(scrResetReq), .txData(txData), .txValid(txValid), .sbStart(sbStart));
`default_nettype wire
